/* core/ecrb_pkg.sv */
// ****************************************
// Register bank constants
// ****************************************
package ecrb_pkg;

  localparam int CFG_N = 31;

  typedef struct packed {
    logic [1:0] bank;
    logic [4:0] addr;
    logic [7:0] mask;
    logic [7:0] rst;
  } ecrb_cfg_s;

  // ****************************************
  // Bank codes and shared window
  // ****************************************
  localparam logic [1:0] BANK0       = 2'h0;
  localparam logic [1:0] BANK1       = 2'h1;
  localparam logic [1:0] BANK2       = 2'h2;
  localparam logic [1:0] BANK3       = 2'h3;
  localparam logic [4:0] ADDR_COMMON = 5'h1B;
  localparam logic [4:0] ADDR_ECON   = 5'h1F;
  localparam logic [4:0] ADDR_CSTAT  = 5'h1E;

  // ****************************************
  // Read-only register addresses
  // ****************************************
  localparam logic [4:0] ADDR_PKTCNT   = 5'h05;
  localparam logic [4:0] ADDR_PHYRD_LO = 5'h0E;
  localparam logic [4:0] ADDR_PHYRD_HI = 5'h0F;
  localparam logic [4:0] ADDR_BSTCSL   = 5'h0C;
  localparam logic [4:0] ADDR_BSTCSH   = 5'h0D;
  localparam logic [4:0] ADDR_PHYSTAT  = 5'h0E;
  localparam logic [4:0] ADDR_REV      = 5'h0F;
  localparam logic [7:0] PHYSTAT_MASK  = 8'h0F;
  localparam logic [7:0] REV_MASK      = 8'h1F;

  // Revision code, value arbitrary
  localparam logic [4:0] REV_DEFAULT = 5'h0A;

  // ****************************************
  // Main control bit positions
  // ****************************************
  localparam int B_TXRST  = 7;
  localparam int B_RXRST  = 6;
  localparam int B_DMA_GO = 5;
  localparam int B_CSUM   = 4;
  localparam int B_TX_REQ = 3;
  localparam int B_RX_ON  = 2;
  localparam logic [7:0] ECON_RST  = 8'h00;
  localparam int         CSTAT_RDY = 0;

  // ****************************************
  // Storage table: bank, addr, mask, reset
  // ****************************************
  localparam int CFG_RXF    = 4;
  localparam int CFG_RETX   = 11;
  localparam int CFG_CLKOUT = 27;

  localparam ecrb_cfg_s CFG_TAB [CFG_N] = '{
    '{BANK1, 5'h00, 8'hFF, 8'h00}, '{BANK1, 5'h01, 8'hFF, 8'h00},
    '{BANK1, 5'h02, 8'hFF, 8'h00}, '{BANK1, 5'h03, 8'h1F, 8'h00},
    '{BANK1, 5'h04, 8'hFF, 8'hA1}, '{BANK2, 5'h00, 8'h1F, 8'h00},
    '{BANK2, 5'h01, 8'hFF, 8'h00}, '{BANK2, 5'h02, 8'h73, 8'h00},
    '{BANK2, 5'h03, 8'h7F, 8'h00}, '{BANK2, 5'h04, 8'h7F, 8'h00},
    '{BANK2, 5'h05, 8'h7F, 8'h00}, '{BANK2, 5'h06, 8'h0F, 8'h0F},
    '{BANK2, 5'h07, 8'h3F, 8'h37}, '{BANK2, 5'h08, 8'hFF, 8'h00},
    '{BANK2, 5'h09, 8'hFF, 8'h06}, '{BANK2, 5'h0A, 8'h03, 8'h00},
    '{BANK2, 5'h0B, 8'h1F, 8'h00}, '{BANK2, 5'h0C, 8'hFF, 8'h00},
    '{BANK2, 5'h0D, 8'hFF, 8'h00}, '{BANK3, 5'h00, 8'hFF, 8'h00},
    '{BANK3, 5'h01, 8'hFF, 8'h00}, '{BANK3, 5'h02, 8'hFF, 8'h00},
    '{BANK3, 5'h03, 8'hFF, 8'h00}, '{BANK3, 5'h04, 8'hFF, 8'h00},
    '{BANK3, 5'h05, 8'hFF, 8'h00}, '{BANK3, 5'h06, 8'hFF, 8'h00},
    '{BANK3, 5'h07, 8'hFF, 8'h00}, '{BANK3, 5'h08, 8'h07, 8'h04},
    '{BANK3, 5'h09, 8'h07, 8'h00}, '{BANK3, 5'h0A, 8'hFF, 8'h00},
    '{BANK3, 5'h0B, 8'hFF, 8'h10}
  };

endpackage : ecrb_pkg

/* core/ecrb_reg.sv */
`timescale 1ns/1ns
// ****************************************
// One byte of host storage
// ****************************************
module ecrb_reg
  import ecrb_pkg::*;
#(
  parameter logic [7:0] RST      = 8'h00,
  parameter logic [7:0] MASK     = 8'hFF,
  parameter bit         POR_ONLY = 1'b0
) (
  // Clock and resets
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       soft_rst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST;
    end else if (soft_rst && !POR_ONLY) begin
      q <= RST;
    end else if (wr_en) begin
      q <= wdata & MASK;
    end
  end

endmodule : ecrb_reg

/* core/ecrb_bank.sv */
`timescale 1ns/1ns
// Behaviour
// RULE1 - Clock-out field loads 100 on power-on reset, keeps value on other resets.
// RULE2 - Clock-ready flag clears on power-on reset, untouched by other resets.
// RULE3 - Revision register is read-only, five-bit value in low bits.
// RULE4 - Host keeps reserved bits at their current values when writing.
// RULE5 - Main control holds receive, transmit, DMA and bank bits, host writable.
// RULE6 - Bank field value 0 to 3 routes later accesses to that bank.
// RULE7 - Unimplemented bits read zero and ignore writes.
// RULE8 - Other bits load their reset value on any device reset.
module ecrb_bank
  import ecrb_pkg::*;
#(
  parameter logic [4:0] REVISION = REV_DEFAULT
) (
  // Clock and resets
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               soft_rst,
  // Host register port
  input  wire logic [4:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  // Device status inputs
  input  wire logic               osc_ready,
  input  wire logic               tx_done,
  input  wire logic               dma_done,
  input  wire logic [7:0]         pkt_count,
  input  wire logic [15:0]        phy_rd_data,
  input  wire logic [3:0]         phy_status,
  input  wire logic [15:0]        bist_sum,
  // Control outputs
  output logic      [CFG_N*8-1:0] cfg_q,
  output logic      [2:0]         clkout_sel,
  output logic                    clock_ready,
  output logic                    tx_logic_rst,
  output logic                    rx_logic_rst,
  output logic                    dma_start,
  output logic                    dma_csum_en,
  output logic                    tx_request,
  output logic                    rx_enable,
  output logic      [1:0]         bank_sel
);

  // ****************************************
  // Address decode helpers
  // ****************************************
  function automatic logic bank_hit(input logic [1:0] bank,
                                    input logic [1:0] sel,
                                    input logic [4:0] addr,
                                    input logic [4:0] want);
    bank_hit = (sel == bank) && (addr == want);
  endfunction : bank_hit

  function automatic logic [7:0] hold_bits(input logic [7:0] v,
                                           input logic [7:0] m);
    hold_bits = v & m;
  endfunction : hold_bits

  // ****************************************
  // State
  // ****************************************
  logic [7:0]       econ_r;
  logic [7:0]       econ_nxt;
  logic             clk_ready_r;
  logic [7:0]       rdata_r;
  logic [7:0]       rd_mux;
  logic [CFG_N-1:0] cfg_wr;
  logic [CFG_N-1:0] cfg_sel;
  logic [7:0]       cfg_byte [CFG_N];

  // ****************************************
  // Decode
  // ****************************************
  wire is_common = (reg_addr >= ADDR_COMMON);
  wire sel_econ  = (reg_addr == ADDR_ECON);
  wire sel_cstat = (reg_addr == ADDR_CSTAT);
  wire wr_econ   = reg_wr && sel_econ;

  wire [1:0] bsel = econ_r[1:0];

  wire sel_pkt   = bank_hit(BANK1, bsel, reg_addr, ADDR_PKTCNT); // RULE6
  wire sel_phyrd_lo = bank_hit(BANK2, bsel, reg_addr, ADDR_PHYRD_LO);
  wire sel_phyrd_hi = bank_hit(BANK2, bsel, reg_addr, ADDR_PHYRD_HI);
  wire sel_bstl     = bank_hit(BANK3, bsel, reg_addr, ADDR_BSTCSL);
  wire sel_bsth     = bank_hit(BANK3, bsel, reg_addr, ADDR_BSTCSH);
  wire sel_mist     = bank_hit(BANK3, bsel, reg_addr, ADDR_PHYSTAT);
  wire sel_rev   = bank_hit(BANK3, bsel, reg_addr, ADDR_REV);

  // ****************************************
  // Storage bytes
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < CFG_N; g++) begin : g_cfg
      assign cfg_sel[g] = !is_common &&
        bank_hit(CFG_TAB[g].bank, bsel, reg_addr, CFG_TAB[g].addr); // RULE6
      assign cfg_wr[g]  = reg_wr && cfg_sel[g];

      ecrb_reg #(
        .RST      (CFG_TAB[g].rst),
        .MASK     (CFG_TAB[g].mask),
        .POR_ONLY (g == CFG_CLKOUT)
      ) u_reg (
        .clk      (clk),
        .arst_n   (arst_n),
        .soft_rst (soft_rst),
        .wr_en    (cfg_wr[g]),
        .wdata    (reg_wdata),
        .q        (cfg_byte[g])
      ); // RULE1 RULE7 RULE8

      assign cfg_q[g*8 +: 8] = cfg_byte[g];
    end
  endgenerate

  assign clkout_sel = cfg_byte[CFG_CLKOUT][2:0]; // RULE1

  // ****************************************
  // Main control register
  // ****************************************
  always_comb begin
    econ_nxt = econ_r;
    if (dma_done) begin
      econ_nxt[B_DMA_GO] = 1'b0;
    end
    if (tx_done) begin
      econ_nxt[B_TX_REQ] = 1'b0;
    end
    if (wr_econ) begin
      econ_nxt = reg_wdata; // RULE5
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      econ_r <= ECON_RST;
    end else if (soft_rst) begin
      econ_r <= ECON_RST; // RULE8
    end else begin
      econ_r <= econ_nxt;
    end
  end

  assign tx_logic_rst = econ_r[B_TXRST];
  assign rx_logic_rst = econ_r[B_RXRST];
  assign dma_start    = econ_r[B_DMA_GO];
  assign dma_csum_en  = econ_r[B_CSUM];
  assign tx_request   = econ_r[B_TX_REQ];
  assign rx_enable    = econ_r[B_RX_ON];
  assign bank_sel     = bsel;

  // ****************************************
  // Clock-ready flag
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_ready_r <= 1'b0; // RULE2
    end else begin
      clk_ready_r <= osc_ready; // RULE2
    end
  end

  assign clock_ready = clk_ready_r;

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rd_mux = 8'h00; // RULE7
    for (int i = 0; i < CFG_N; i++) begin
      if (cfg_sel[i]) begin
        rd_mux = hold_bits(cfg_byte[i], CFG_TAB[i].mask); // RULE7
      end
    end
    if (is_common) begin
      rd_mux = 8'h00;
      if (sel_econ) begin
        rd_mux = econ_r;
      end
      if (sel_cstat) begin
        rd_mux[CSTAT_RDY] = clk_ready_r;
      end
    end
    if (sel_pkt) begin
      rd_mux = pkt_count;
    end
    if (sel_phyrd_lo) begin
      rd_mux = phy_rd_data[7:0];
    end
    if (sel_phyrd_hi) begin
      rd_mux = phy_rd_data[15:8];
    end
    if (sel_bstl) begin
      rd_mux = bist_sum[7:0];
    end
    if (sel_bsth) begin
      rd_mux = bist_sum[15:8];
    end
    if (sel_mist) begin
      rd_mux = hold_bits({4'h0, phy_status}, PHYSTAT_MASK); // RULE7
    end
    if (sel_rev) begin
      rd_mux = hold_bits({3'h0, REVISION}, REV_MASK); // RULE3
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  wire rd_rev  = reg_rd && sel_rev;
  wire rd_mac1 = reg_rd && cfg_sel[5];
  wire keep_co = soft_rst && !cfg_wr[CFG_CLKOUT];

  wire [7:0] ctl_bits = {tx_logic_rst, rx_logic_rst, dma_start, dma_csum_en,
                         tx_request, rx_enable, bank_sel};

  sequence s_wr_rxf;
    cfg_wr[CFG_RXF] && !soft_rst;
  endsequence

  sequence s_rd_rxf;
    reg_rd && cfg_sel[CFG_RXF];
  endsequence

  AST_CO_POR: assert property ($rose(arst_n) |-> clkout_sel == 3'h4) // RULE1
    else $error("clock-out field not 100 after power-on reset");

  AST_CO_KEEP: assert property (keep_co |=> $stable(clkout_sel)) // RULE1
    else $error("clock-out field changed by soft reset");

  AST_RDY_KEEP: assert property (soft_rst |=> clock_ready == $past(osc_ready)) // RULE2
    else $error("clock-ready flag disturbed by soft reset");

  AST_RDY_POR: assert property ($rose(arst_n) |-> !clock_ready) // RULE2
    else $error("clock-ready flag set at power-on release");

  AST_REV_RO: assert property (rd_rev |=> reg_rdata == {3'h0, REVISION}) // RULE3
    else $error("revision read wrong");

  AST_BANK_WR: assert property (wr_econ && !soft_rst |=> // RULE6
    bank_sel == $past(reg_wdata[1:0]))
    else $error("bank field not written");

  AST_ECON_WR: assert property (wr_econ && !soft_rst |=> // RULE5
    rx_enable == $past(reg_wdata[B_RX_ON]))
    else $error("receive enable not written");

  AST_DMA_CLR: assert property (dma_done && !wr_econ |=> !dma_start) // RULE5
    else $error("DMA start not cleared");

  AST_UNIMP: assert property (rd_mac1 |=> reg_rdata[7:5] == 3'h0) // RULE7
    else $error("unimplemented bits read nonzero");

  AST_SOFT: assert property (soft_rst |=> cfg_byte[CFG_RETX] == 8'h0F && bank_sel == 2'h0) // RULE8
    else $error("soft reset values wrong");

  AST_WR_RD: assert property (s_wr_rxf ##1 s_rd_rxf |=>
    reg_rdata == $past(reg_wdata, 2)) // RULE6
    else $error("filter byte write then read mismatch");

  AST_CO_WR: assert property (cfg_wr[CFG_CLKOUT] |=> // RULE1
    clkout_sel == $past(reg_wdata[2:0]))
    else $error("clock-out field write lost");

  AST_UNIMP_CO: assert property (reg_rd && cfg_sel[CFG_CLKOUT] |=> // RULE7
    reg_rdata[7:3] == 5'h00)
    else $error("clock-out unused bits read nonzero");

  AST_RDY_FOLLOW: assert property (osc_ready |=> clock_ready) // RULE2
    else $error("clock-ready flag did not set");

  AST_RDY_LOW: assert property (!osc_ready |=> !clock_ready) // RULE2
    else $error("clock-ready flag did not clear");

  AST_CSTAT_RD: assert property (reg_rd && sel_cstat |=> // RULE2
    reg_rdata[CSTAT_RDY] == $past(clock_ready))
    else $error("clock status read wrong");

  AST_CSTAT_HI: assert property (reg_rd && sel_cstat |=> reg_rdata[7:1] == 7'h00) // RULE7
    else $error("clock status unused bits nonzero");

  AST_REV_NOWR: assert property (reg_wr && sel_rev |-> cfg_wr == '0) // RULE3
    else $error("revision write reached storage");

  AST_ECON_RD: assert property (reg_rd && sel_econ |=> reg_rdata == $past(ctl_bits)) // RULE5
    else $error("main control read wrong");

  AST_ECON_ALL: assert property (wr_econ && !soft_rst |=> // RULE5
    ctl_bits == $past(reg_wdata))
    else $error("main control write lost");

  AST_TX_CLR: assert property (tx_done && !wr_econ |=> !tx_request) // RULE5
    else $error("transmit request not cleared");

  AST_ECON_HOLD: assert property (!wr_econ && !soft_rst && !tx_done && !dma_done |=> // RULE5
    $stable(ctl_bits))
    else $error("main control changed by itself");

  AST_BANK_ROUTE: assert property (reg_rd && cfg_sel[CFG_RXF] |=> // RULE6
    reg_rdata == $past(cfg_q[CFG_RXF*8 +: 8]))
    else $error("filter byte read wrong");

  AST_BANK0_RD: assert property (reg_rd && bsel == BANK0 && !is_common |=> // RULE6
    reg_rdata == 8'h00)
    else $error("bank 0 read nonzero");

  AST_BANK0_WR: assert property (reg_wr && bsel == BANK0 |-> cfg_wr == '0) // RULE6
    else $error("bank 0 write reached storage");

  AST_SEL_ONE: assert property ($onehot0(cfg_sel)) // RULE6
    else $error("two storage bytes selected");

  AST_UNMAP_RD: assert property (reg_rd && bsel == BANK1 && !is_common && // RULE7
    reg_addr > ADDR_PKTCNT |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");

  AST_UNIMP_RETX: assert property (reg_rd && cfg_sel[CFG_RETX] |=> // RULE7
    reg_rdata[7:4] == 4'h0)
    else $error("retransmit unused bits read nonzero");

  AST_PHYSTAT_HI: assert property (reg_rd && sel_mist |=> reg_rdata[7:4] == 4'h0) // RULE7
    else $error("status unused bits read nonzero");

  AST_CFG_MASK: assert property (cfg_wr[CFG_RETX] && !soft_rst |=> // RULE7
    cfg_q[CFG_RETX*8 +: 8] == ($past(reg_wdata) & CFG_TAB[CFG_RETX].mask))
    else $error("retransmit write not masked");

  AST_SOFT_RXF: assert property (soft_rst |=> // RULE8
    cfg_q[CFG_RXF*8 +: 8] == CFG_TAB[CFG_RXF].rst)
    else $error("filter byte not reset by soft reset");

  AST_SOFT_ECON: assert property (soft_rst |=> ctl_bits == ECON_RST) // RULE8
    else $error("main control not reset by soft reset");

  AST_POR_RXF: assert property ($rose(arst_n) |-> // RULE8
    cfg_q[CFG_RXF*8 +: 8] == CFG_TAB[CFG_RXF].rst)
    else $error("filter byte not reset at power-on");

  AST_POR_ECON: assert property ($rose(arst_n) |-> ctl_bits == ECON_RST) // RULE8
    else $error("main control not reset at power-on");

  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

endmodule : ecrb_bank

/* test/ecrb_host.sv */
`timescale 1ns/1ns
// ****************************************
// Host side of the register port
// ****************************************
module ecrb_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [4:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  // Write then read the same address back to back
  task automatic wr_rd(input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    @(negedge clk);
    reg_rd    = 1'b0;
    q         = reg_rdata;
  endtask : wr_rd

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask : rd

  // Touches only the bits in m, keeps the rest
  task automatic rmw(input logic [4:0] a, input logic [7:0] m, input logic [7:0] d);
    logic [7:0] v;
    rd(a, v);
    wr(a, (v & ~m) | (d & m));
  endtask : rmw
endmodule : ecrb_host

/* test/ethernet_ctrl_register_bank_tb_top.sv */
`timescale 1ns/1ns
// ****************************************
// Register bank bench
// ****************************************
module ethernet_ctrl_register_bank_tb_top
  import ecrb_pkg::*;
;
  localparam logic [4:0] REV_T = 5'h15;

  logic               clk = 1'b0;
  logic               arst_n, soft_rst, osc_ready, tx_done, dma_done;
  logic [4:0]         reg_addr;
  logic               reg_wr, reg_rd;
  logic [7:0]         reg_wdata, reg_rdata, pkt_count;
  logic [15:0]        phy_rd_data, bist_sum;
  logic [3:0]         phy_status;
  logic [CFG_N*8-1:0] cfg_q;
  logic [2:0]         clkout_sel;
  logic               clock_ready, tx_logic_rst, rx_logic_rst, dma_start;
  logic               dma_csum_en, tx_request, rx_enable;
  logic [1:0]         bank_sel;
  logic [7:0]         ctl;
  logic [7:0]         rd_v;
  int                 err_count = 0;
  int                 n_tests = 0;

  assign ctl = {tx_logic_rst, rx_logic_rst, dma_start, dma_csum_en,
                tx_request, rx_enable, bank_sel};

  always #10 clk = ~clk;

  ecrb_bank #(.REVISION(REV_T)) i_dut (
    .clk(clk), .arst_n(arst_n), .soft_rst(soft_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .osc_ready(osc_ready), .tx_done(tx_done), .dma_done(dma_done),
    .pkt_count(pkt_count), .phy_rd_data(phy_rd_data), .phy_status(phy_status),
    .bist_sum(bist_sum), .cfg_q(cfg_q), .clkout_sel(clkout_sel),
    .clock_ready(clock_ready), .tx_logic_rst(tx_logic_rst),
    .rx_logic_rst(rx_logic_rst), .dma_start(dma_start), .dma_csum_en(dma_csum_en),
    .tx_request(tx_request), .rx_enable(rx_enable), .bank_sel(bank_sel));

  ecrb_host i_host (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.rd(a, v);
    chk(v, e);
  endtask : rchk

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse

  // Run limit
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end

  initial begin
    arst_n      = 1'b0;
    soft_rst    = 1'b0;
    osc_ready   = 1'b0;
    tx_done     = 1'b0;
    dma_done    = 1'b0;
    pkt_count   = 8'h5A;
    phy_rd_data = 16'hC33C;
    phy_status  = 4'h9;
    bist_sum    = 16'h1234;
    repeat (10) @(negedge clk);
    chk({5'h00, clkout_sel}, 8'h04);
    chk({7'h00, clock_ready}, 8'h00);
    arst_n = 1'b1;
    chk(ctl, ECON_RST);
    // Reset value, writable bits and bank of every stored byte
    for (int i = 0; i < CFG_N; i++) begin
      i_host.wr(ADDR_ECON, {6'h00, CFG_TAB[i].bank});
      chk({6'h00, bank_sel}, {6'h00, CFG_TAB[i].bank});
      rchk(CFG_TAB[i].addr, CFG_TAB[i].rst);
      i_host.wr(CFG_TAB[i].addr, 8'hFF);
      rchk(CFG_TAB[i].addr, CFG_TAB[i].mask);
      chk(cfg_q[8*i +: 8], CFG_TAB[i].mask);
    end
    // Bank 0 holds nothing
    i_host.wr(ADDR_ECON, 8'h00);
    i_host.wr(5'h00, 8'h5A);
    rchk(5'h00, 8'h00);
    // Read-only sources behind their addresses in banks 1, 2 and 3
    i_host.wr(ADDR_ECON, 8'h01);
    i_host.wr(ADDR_PKTCNT, 8'h00);
    rchk(ADDR_PKTCNT, 8'h5A);
    rchk(5'h10, 8'h00);
    i_host.wr_rd(CFG_TAB[CFG_RXF].addr, 8'h3C, rd_v);
    chk(rd_v, 8'h3C);
    i_host.wr(ADDR_ECON, 8'h02);
    rchk(ADDR_PHYRD_LO, 8'h3C);
    rchk(ADDR_PHYRD_HI, 8'hC3);
    i_host.wr(ADDR_ECON, 8'h03);
    rchk(ADDR_BSTCSL, 8'h34);
    rchk(ADDR_BSTCSH, 8'h12);
    rchk(ADDR_PHYSTAT, 8'h09);
    i_host.wr(ADDR_REV, 8'hFF);
    rchk(ADDR_REV, {3'h0, REV_T});
    // Main control bits, then hardware clears
    i_host.wr(ADDR_ECON, 8'hFE);
    chk(ctl, 8'hFE);
    rchk(ADDR_ECON, 8'hFE);
    pulse(tx_done);
    pulse(dma_done);
    chk(ctl, 8'hD6);
    // Soft reset keeps clock-out and clock-ready
    i_host.wr(ADDR_ECON, 8'h03);
    osc_ready = 1'b1;
    i_host.wr(5'h08, 8'h02);
    i_host.wr(5'h0B, 8'h77);
    i_host.rmw(5'h09, 8'h03, 8'h01);
    rchk(5'h09, 8'h05);
    pulse(soft_rst);
    chk({5'h00, clkout_sel}, 8'h02);
    chk({7'h00, clock_ready}, 8'h01);
    chk(ctl, ECON_RST);
    i_host.wr(ADDR_ECON, 8'h03);
    rchk(5'h0B, 8'h10);
    rchk(ADDR_CSTAT, 8'h01);
    rchk(5'h08, 8'h02);
    // Power-on reset again
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    chk({5'h00, clkout_sel}, 8'h04);
    chk({7'h00, clock_ready}, 8'h00);
    arst_n = 1'b1;
    i_host.wr(ADDR_ECON, 8'h03);
    rchk(5'h08, 8'h04);
    rchk(5'h0B, 8'h10);
    rchk(ADDR_CSTAT, 8'h01);
    print_verdict();
  end
endmodule : ethernet_ctrl_register_bank_tb_top
